//--- drr_periph_model.sv
/*
  drr_periph_model: the peripheral request lines that feed the router.
  Assumes: the bench says which lines to raise; slow mode answers one
  cycle later, as a peripheral behind its own pipeline would.
*/
`timescale 1ns/1ns
`default_nettype none

module drr_periph_model (
  // clock
  input  wire logic                    i_sys_clk,
  // control from the bench
  input  wire logic [16:0]             i_raise,
  input  wire logic                    i_slow,
  // request lines, bit 0 is the dac line
  output var drr_pkg::drr_periph_req_t o_req
);
  logic [16:0] stage_q;

  always_ff @(posedge i_sys_clk) begin
    stage_q <= i_raise;
    o_req   <= drr_pkg::drr_periph_req_t'(i_slow ? stage_q : i_raise);
  end
endmodule

`default_nettype wire

//--- drr_pkg.sv
/*
  drr_pkg: shared constants and carrier types for the request routing and
  channel reset block of a five-channel peripheral transfer controller.
  Assumes: used with package-qualified names only, no import.
*/
`default_nettype none

package drr_pkg;
  localparam int unsigned NUM_CH   = 5;
  localparam int unsigned SEL_W    = 6;
  localparam int unsigned NUM_SRC  = 20;
  localparam int unsigned ADDR_W   = 12;

  // byte addresses of the register words
  localparam logic [11:0] OFS_DONE   = 12'h424;
  localparam logic [11:0] OFS_CHRST  = 12'h460;
  localparam logic [11:0] OFS_SEL03  = 12'h480;
  localparam logic [11:0] OFS_SEL4   = 12'h484;
  localparam logic [11:0] OFS_MEMMEM = 12'h490;

  // selector field positions inside the two select words
  localparam int unsigned SEL0_LSB = 0;
  localparam int unsigned SEL1_LSB = 8;
  localparam int unsigned SEL2_LSB = 16;
  localparam int unsigned SEL3_LSB = 24;
  localparam int unsigned SEL4_LSB = 0;

  localparam logic [5:0]  SEL_RST   = 6'h00;
  localparam logic [4:0]  CHRST_RST = 5'h00;
  localparam logic [4:0]  DONE_RST  = 5'h00;
  localparam logic [31:0] UNMAPPED_RDATA = 32'h0000_0000;

  // selector codes
  localparam logic [5:0] SRC_NONE      = 6'h00;
  localparam logic [5:0] SRC_DAC_TX    = 6'h01;
  localparam logic [5:0] SRC_SECOND_UART_TRANSMIT_REQUEST  = 6'h04;
  localparam logic [5:0] SRC_SECOND_UART_RECEIVE_REQUEST  = 6'h05;
  localparam logic [5:0] SRC_UART2_TX  = 6'h06;
  localparam logic [5:0] SRC_UART2_RX  = 6'h07;
  localparam logic [5:0] SRC_SU1_TX    = 6'h0a;
  localparam logic [5:0] SRC_SU1_RX    = 6'h0b;
  localparam logic [5:0] SRC_SU2_TX    = 6'h0c;
  localparam logic [5:0] SRC_SU2_RX    = 6'h0d;
  localparam logic [5:0] SRC_ADC_RX    = 6'h14;
  localparam logic [5:0] SRC_PWM1_RX   = 6'h15;
  localparam logic [5:0] SRC_PWM2_RX   = 6'h16;
  localparam logic [5:0] SRC_PWM3_RX   = 6'h17;
  localparam logic [5:0] SRC_TIMER0_REQUEST      = 6'h20;
  localparam logic [5:0] SRC_TMR1      = 6'h21;
  localparam logic [5:0] SRC_TMR2      = 6'h22;
  localparam logic [5:0] SRC_TIMER3_REQUEST      = 6'h23;

  // peripheral request lines, one bit each
  typedef struct packed {
    logic timer3_request;
    logic timer2_request;
    logic timer1_request;
    logic timer0_request;
    logic pwm_pair3_receive_request;
    logic pwm_pair2_receive_request;
    logic pwm_pair1_receive_request;
    logic adc_receive_request;
    logic second_serial_unit_receive_request;
    logic second_serial_unit_transmit_request;
    logic first_serial_unit_receive_request;
    logic first_serial_unit_transmit_request;
    logic second_uart_receive_request;
    logic second_uart_transmit_request;
    logic first_uart_receive_request;
    logic first_uart_transmit_request;
    logic dac_transmit_request;
  } drr_periph_req_t;

  typedef enum logic [0:0] {
    BUS_IDLE,
    BUS_ACK
  } drr_bus_st_t;

  typedef struct packed {
    drr_bus_st_t bus_st;
    logic [31:0] rdata;
    logic [4:0]  chrst;
    logic [4:0]  done;
    logic [4:0]  memmem;
    logic [5:0]  sel0;
    logic [5:0]  sel1;
    logic [5:0]  sel2;
    logic [5:0]  sel3;
    logic [5:0]  sel4;
    logic [4:0]  route;
  } drr_state_t;
endpackage

`default_nettype wire

//--- drr_src_mux.sv
/*
  drr_src_mux: decodes one 6-bit request selector into a request bit.
  Assumes: request lines already synchronous to the system clock.
*/
`timescale 1ns/1ns
`default_nettype none

module drr_src_mux (
  // selection
  input  wire logic [5:0]           i_sel,
  input  wire logic                 i_mem_to_mem,
  // peripheral request lines
  input  wire drr_pkg::drr_periph_req_t i_req,
  // routed request
  output logic                      o_req
);
  always_comb begin
    o_req = 1'b0;
    if (!i_mem_to_mem) begin // R13
      case (i_sel)
        drr_pkg::SRC_DAC_TX:   o_req = i_req.dac_transmit_request; // R6
        drr_pkg::SRC_SECOND_UART_TRANSMIT_REQUEST: o_req = i_req.first_uart_transmit_request; // R7
        drr_pkg::SRC_SECOND_UART_RECEIVE_REQUEST: o_req = i_req.first_uart_receive_request;
        drr_pkg::SRC_UART2_TX: o_req = i_req.second_uart_transmit_request;
        drr_pkg::SRC_UART2_RX: o_req = i_req.second_uart_receive_request;
        drr_pkg::SRC_SU1_TX: begin // R8
          o_req = i_req.first_serial_unit_transmit_request;
        end
        drr_pkg::SRC_SU1_RX: begin
          o_req = i_req.first_serial_unit_receive_request;
        end
        drr_pkg::SRC_SU2_TX: begin
          o_req = i_req.second_serial_unit_transmit_request;
        end
        drr_pkg::SRC_SU2_RX: begin
          o_req = i_req.second_serial_unit_receive_request;
        end
        drr_pkg::SRC_ADC_RX:  o_req = i_req.adc_receive_request; // R9
        drr_pkg::SRC_PWM1_RX: o_req = i_req.pwm_pair1_receive_request; // R10
        drr_pkg::SRC_PWM2_RX: o_req = i_req.pwm_pair2_receive_request;
        drr_pkg::SRC_PWM3_RX: o_req = i_req.pwm_pair3_receive_request;
        drr_pkg::SRC_TIMER0_REQUEST:    o_req = i_req.timer0_request; // R11
        drr_pkg::SRC_TMR1:    o_req = i_req.timer1_request;
        drr_pkg::SRC_TMR2:    o_req = i_req.timer2_request;
        drr_pkg::SRC_TIMER3_REQUEST:    o_req = i_req.timer3_request;
        // zero, reserved and out-of-range codes connect nothing
        default:              o_req = 1'b0; // R5 R16
      endcase
    end
  end
endmodule

`default_nettype wire

//--- drr_top.sv
/*
  drr_top: request routing and per-channel reset for a five-channel
  peripheral transfer controller, with an Avalon-MM register slave.
  Assumes: one 25 MHz clock, synchronous active-high reset, request and
  done inputs synchronous to that clock; the transfer engine outside
  consumes o_ch_req and o_ch_reset.
*/
// Chosen here: the Avalon-MM slave port.
// How it works
// R1 - writing one resets that channel
// R2 - channel 0 selector at bits 5:0
// R3 - channels 1-3 selectors at 13:8, 21:16, 29:24
// R4 - channel 4 selector in second word
// R5 - selector zero connects no request
// R6 - code 1 routes DAC transmit
// R7 - codes 4-7 route both UARTs
// R8 - codes 10-13 route both serial units
// R9 - code 20 routes ADC receive
// R10 - codes 21-23 route PWM pair receives
// R11 - codes 32-35 route timers 0-3
// R12 - software never selects one source twice
// R13 - memory-to-memory channel ignores its selector
// R14 - all selectors and resets read zero
// R15 - done flag set on finish, write-one clears
// R16 - reserved or large codes connect nothing
`timescale 1ns/1ns
`default_nettype none

module drr_top #(
  parameter int unsigned NUM_CH = drr_pkg::NUM_CH
) (
  // clock and reset
  input  wire logic                     i_sys_clk,
  input  wire logic                     i_srst,
  input  wire logic                     i_clk_en,
  // avalon-mm slave
  input  wire logic [11:0]              i_avs_address,
  input  wire logic                     i_avs_read,
  input  wire logic                     i_avs_write,
  input  wire logic [31:0]              i_avs_writedata,
  input  wire logic [3:0]               i_avs_byteenable,
  output logic [31:0]                   o_avs_readdata,
  output logic                          o_avs_waitrequest,
  // peripheral request lines
  input  wire drr_pkg::drr_periph_req_t i_periph_req,
  // transfer engine
  input  wire logic [4:0]               i_ch_done,
  output logic [4:0]                    o_ch_req,
  output logic [4:0]                    o_ch_reset,
  output logic [4:0]                    o_ch_done_flag
);
  drr_pkg::drr_state_t s_q;
  drr_pkg::drr_state_t s_d;
  logic [4:0]          route_w;
  logic [5:0]          sel_w [5];
  logic                wr_go;
  logic                rd_go;
  logic [31:0]         wmask;
  logic [31:0]         wd;

  assign sel_w[0] = s_q.sel0;
  assign sel_w[1] = s_q.sel1;
  assign sel_w[2] = s_q.sel2;
  assign sel_w[3] = s_q.sel3;
  assign sel_w[4] = s_q.sel4;

  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : g_ch
      drr_src_mux u_mux (
        .i_sel        (sel_w[g]),
        .i_mem_to_mem (s_q.memmem[g]),
        .i_req        (i_periph_req),
        .o_req        (route_w[g])
      );
    end
  endgenerate

  // one wait cycle per access: the request is taken in BUS_IDLE and
  // answered with waitrequest low in BUS_ACK
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) &&
                             (s_q.bus_st != drr_pkg::BUS_ACK);
  assign wr_go = i_avs_write && s_q.bus_st == drr_pkg::BUS_IDLE;
  assign rd_go = i_avs_read && s_q.bus_st == drr_pkg::BUS_IDLE;
  assign wmask = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                  {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
  assign wd    = i_avs_writedata & wmask;

  always_comb begin
    s_d = s_q;
    // reset pulses last one cycle after the writing access
    s_d.chrst = 5'h00;
    s_d.route = route_w;
    // set wins over the write-one clear
    s_d.done  = s_q.done | i_ch_done; // R15
    case (s_q.bus_st)
      drr_pkg::BUS_IDLE: begin
        if (wr_go) begin
          s_d.bus_st = drr_pkg::BUS_ACK;
          case (i_avs_address)
            drr_pkg::OFS_CHRST: begin
              s_d.chrst = wd[4:0]; // R1
            end
            drr_pkg::OFS_DONE: begin
              s_d.done = (s_q.done & ~wd[4:0]) | i_ch_done; // R15
            end
            drr_pkg::OFS_SEL03: begin
              if (i_avs_byteenable[0]) begin
                s_d.sel0 = i_avs_writedata[drr_pkg::SEL0_LSB +: 6]; // R2
              end
              if (i_avs_byteenable[1]) begin
                s_d.sel1 = i_avs_writedata[drr_pkg::SEL1_LSB +: 6]; // R3
              end
              if (i_avs_byteenable[2]) begin
                s_d.sel2 = i_avs_writedata[drr_pkg::SEL2_LSB +: 6];
              end
              if (i_avs_byteenable[3]) begin
                s_d.sel3 = i_avs_writedata[drr_pkg::SEL3_LSB +: 6];
              end
            end
            drr_pkg::OFS_SEL4: begin
              if (i_avs_byteenable[0]) begin
                s_d.sel4 = i_avs_writedata[drr_pkg::SEL4_LSB +: 6]; // R4
              end
            end
            drr_pkg::OFS_MEMMEM: begin
              if (i_avs_byteenable[0]) begin
                s_d.memmem = i_avs_writedata[4:0]; // R13
              end
            end
            default: begin
            end
          endcase
        end else if (rd_go) begin
          s_d.bus_st = drr_pkg::BUS_ACK;
          case (i_avs_address)
            drr_pkg::OFS_CHRST:  s_d.rdata = {27'h0, s_q.chrst};
            drr_pkg::OFS_DONE:   s_d.rdata = {27'h0, s_q.done};
            drr_pkg::OFS_SEL03: begin
              s_d.rdata = {2'h0, s_q.sel3, 2'h0, s_q.sel2,
                           2'h0, s_q.sel1, 2'h0, s_q.sel0};
            end
            drr_pkg::OFS_SEL4:   s_d.rdata = {26'h0, s_q.sel4};
            drr_pkg::OFS_MEMMEM: s_d.rdata = {27'h0, s_q.memmem};
            default:             s_d.rdata = drr_pkg::UNMAPPED_RDATA;
          endcase
        end
      end
      drr_pkg::BUS_ACK: begin
        s_d.bus_st = drr_pkg::BUS_IDLE;
      end
      default: begin
        s_d.bus_st = drr_pkg::BUS_IDLE;
      end
    endcase
    // a reset channel drops its done flag
    s_d.done = s_d.done & ~s_q.chrst;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      s_q.bus_st <= drr_pkg::BUS_IDLE;
      s_q.rdata  <= 32'h0000_0000;
      s_q.chrst  <= drr_pkg::CHRST_RST; // R14
      s_q.done   <= drr_pkg::DONE_RST;
      s_q.memmem <= 5'h00;
      s_q.sel0   <= drr_pkg::SEL_RST; // R14
      s_q.sel1   <= drr_pkg::SEL_RST;
      s_q.sel2   <= drr_pkg::SEL_RST;
      s_q.sel3   <= drr_pkg::SEL_RST;
      s_q.sel4   <= drr_pkg::SEL_RST;
      s_q.route  <= 5'h00;
    end else if (i_clk_en) begin
      s_q <= s_d;
    end
  end

  assign o_avs_readdata = s_q.rdata;
  assign o_ch_req       = s_q.route;
  assign o_ch_reset     = s_q.chrst;
  assign o_ch_done_flag = s_q.done;

  // checks
  // high from the first edge on, so no check looks back before time zero
  logic past_ok;
  always_ff @(posedge i_sys_clk) begin
    past_ok <= 1'b1;
  end

  chrst_pulse_a: assert property (@(posedge i_sys_clk) disable iff (i_srst) // R1
    (i_clk_en && wr_go && i_avs_address == drr_pkg::OFS_CHRST &&
     i_avs_byteenable[0])
    |=> o_ch_reset == $past(i_avs_writedata[4:0]))
    else $error("channel reset not pulsed as written");

  chrst_once_a: assert property (@(posedge i_sys_clk) disable iff (i_srst) // R1
    (i_clk_en && o_ch_reset != 5'h00) |=> o_ch_reset == 5'h00)
    else $error("channel reset held too long");

  sel0_write_a: assert property (@(posedge i_sys_clk) disable iff (i_srst) // R2
    (i_clk_en && wr_go && i_avs_address == drr_pkg::OFS_SEL03 &&
     i_avs_byteenable[0])
    |=> s_q.sel0 == $past(i_avs_writedata[5:0]))
    else $error("channel 0 selector not stored");

  sel3_write_a: assert property (@(posedge i_sys_clk) disable iff (i_srst) // R3
    (i_clk_en && wr_go && i_avs_address == drr_pkg::OFS_SEL03 &&
     i_avs_byteenable[3])
    |=> s_q.sel3 == $past(i_avs_writedata[29:24]))
    else $error("channel 3 selector not stored");

  sel4_write_a: assert property (@(posedge i_sys_clk) disable iff (i_srst) // R4
    (i_clk_en && wr_go && i_avs_address == drr_pkg::OFS_SEL4 &&
     i_avs_byteenable[0])
    |=> s_q.sel4 == $past(i_avs_writedata[5:0]))
    else $error("channel 4 selector not stored");

  zero_sel_a: assert property (@(posedge i_sys_clk) disable iff (i_srst) // R5
    (i_clk_en && s_q.sel0 == drr_pkg::SRC_NONE) |=> !o_ch_req[0])
    else $error("request routed with zero selector");

  dac_route_a: assert property (@(posedge i_sys_clk) disable iff (i_srst) // R6
    (i_clk_en && s_q.sel0 == drr_pkg::SRC_DAC_TX && !s_q.memmem[0])
    |=> o_ch_req[0] == $past(i_periph_req.dac_transmit_request))
    else $error("dac request not routed");

  tmr_route_a: assert property (@(posedge i_sys_clk) disable iff (i_srst) // R11
    (i_clk_en && s_q.sel1 == drr_pkg::SRC_TIMER3_REQUEST && !s_q.memmem[1])
    |=> o_ch_req[1] == $past(i_periph_req.timer3_request))
    else $error("timer 3 request not routed");

  memmem_a: assert property (@(posedge i_sys_clk) disable iff (i_srst) // R13
    (i_clk_en && s_q.memmem[0]) |=> !o_ch_req[0])
    else $error("request routed on memory-to-memory channel");

  reserved_a: assert property (@(posedge i_sys_clk) disable iff (i_srst) // R16
    (i_clk_en && (s_q.sel4 > drr_pkg::SRC_TIMER3_REQUEST || s_q.sel4 == 6'h08))
    |=> !o_ch_req[4])
    else $error("reserved selector routed a request");

  done_set_a: assert property (@(posedge i_sys_clk) disable iff (i_srst) // R15
    (i_clk_en && i_ch_done[1] && s_q.chrst[1] == 1'b0) |=> o_ch_done_flag[1])
    else $error("done flag lost");

  reset_zero_a: assert property (@(posedge i_sys_clk) // R14
    (past_ok && $past(i_srst) && !i_srst) |->
    (s_q.sel0 == 6'h00 && s_q.sel1 == 6'h00 && s_q.sel2 == 6'h00 &&
     s_q.sel3 == 6'h00 && s_q.sel4 == 6'h00 && o_ch_reset == 5'h00 &&
     o_ch_req == 5'h00 && o_ch_done_flag == 5'h00))
    else $error("registers not zero after reset");

  sel1_write_a: assert property ( // R3
    @(posedge i_sys_clk) disable iff (i_srst)
    (i_clk_en && wr_go && i_avs_address == drr_pkg::OFS_SEL03 &&
     i_avs_byteenable[1])
    |=> s_q.sel1 == $past(i_avs_writedata[13:8]))
    else $error("channel 1 selector not stored");

  sel2_write_a: assert property ( // R3
    @(posedge i_sys_clk) disable iff (i_srst)
    (i_clk_en && wr_go && i_avs_address == drr_pkg::OFS_SEL03 &&
     i_avs_byteenable[2])
    |=> s_q.sel2 == $past(i_avs_writedata[21:16]))
    else $error("channel 2 selector not stored");

  sel_read_a: assert property ( // R2
    @(posedge i_sys_clk) disable iff (i_srst)
    (i_clk_en && rd_go && i_avs_address == drr_pkg::OFS_SEL03)
    |=> o_avs_readdata[5:0] == $past(s_q.sel0))
    else $error("channel 0 selector read back wrong");

  uart_route_a: assert property ( // R7
    @(posedge i_sys_clk) disable iff (i_srst)
    (i_clk_en && s_q.sel4 == drr_pkg::SRC_UART2_RX && !s_q.memmem[4])
    |=> o_ch_req[4] == $past(i_periph_req.second_uart_receive_request))
    else $error("second uart receive request not routed");

  su_route_a: assert property ( // R8
    @(posedge i_sys_clk) disable iff (i_srst)
    (i_clk_en && s_q.sel0 == drr_pkg::SRC_SU1_TX && !s_q.memmem[0])
    |=> o_ch_req[0] == $past(i_periph_req.first_serial_unit_transmit_request))
    else $error("serial unit transmit request not routed");

  adc_route_a: assert property ( // R9
    @(posedge i_sys_clk) disable iff (i_srst)
    (i_clk_en && s_q.sel4 == drr_pkg::SRC_ADC_RX && !s_q.memmem[4])
    |=> o_ch_req[4] == $past(i_periph_req.adc_receive_request))
    else $error("adc request not routed");

  pwm_route_a: assert property ( // R10
    @(posedge i_sys_clk) disable iff (i_srst)
    (i_clk_en && s_q.sel2 == drr_pkg::SRC_PWM3_RX && !s_q.memmem[2])
    |=> o_ch_req[2] == $past(i_periph_req.pwm_pair3_receive_request))
    else $error("pwm pair 3 request not routed");

  timer0_request_route_a: assert property ( // R11
    @(posedge i_sys_clk) disable iff (i_srst)
    (i_clk_en && s_q.sel3 == drr_pkg::SRC_TIMER0_REQUEST && !s_q.memmem[3])
    |=> o_ch_req[3] == $past(i_periph_req.timer0_request))
    else $error("timer 0 request not routed");

  reserved0_a: assert property ( // R16
    @(posedge i_sys_clk) disable iff (i_srst)
    (i_clk_en && s_q.sel0 inside {6'h08, 6'h09, [6'h0e:6'h13],
     [6'h18:6'h1f], [6'h24:6'h3f]})
    |=> !o_ch_req[0])
    else $error("reserved code routed a request on channel 0");

  zero_sel4_a: assert property ( // R5
    @(posedge i_sys_clk) disable iff (i_srst)
    (i_clk_en && s_q.sel4 == drr_pkg::SRC_NONE)
    |=> !o_ch_req[4])
    else $error("request routed with zero selector on channel 4");

  memmem_write_a: assert property ( // R13
    @(posedge i_sys_clk) disable iff (i_srst)
    (i_clk_en && wr_go && i_avs_address == drr_pkg::OFS_MEMMEM &&
     i_avs_byteenable[0])
    |=> s_q.memmem == $past(i_avs_writedata[4:0]))
    else $error("memory-to-memory bits not stored");

  chrst_zero_a: assert property ( // R1
    @(posedge i_sys_clk) disable iff (i_srst)
    (i_clk_en && wr_go && i_avs_address == drr_pkg::OFS_CHRST &&
     !i_avs_writedata[0])
    |=> !o_ch_reset[0])
    else $error("channel reset pulsed by a zero");

  chrst_done_a: assert property ( // R1
    @(posedge i_sys_clk) disable iff (i_srst)
    (i_clk_en && o_ch_reset[0])
    |=> !o_ch_done_flag[0])
    else $error("reset channel kept its done flag");

  done_clear_a: assert property ( // R15
    @(posedge i_sys_clk) disable iff (i_srst)
    (i_clk_en && wr_go && i_avs_address == drr_pkg::OFS_DONE &&
     i_avs_byteenable[0] && i_avs_writedata[1] && !i_ch_done[1])
    |=> !o_ch_done_flag[1])
    else $error("done flag not cleared by writing one");

  done_win_a: assert property ( // R15
    @(posedge i_sys_clk) disable iff (i_srst)
    (i_clk_en && wr_go && i_avs_address == drr_pkg::OFS_DONE &&
     i_ch_done[4] && !o_ch_reset[4])
    |=> o_ch_done_flag[4])
    else $error("finish lost to a clear in the same cycle");
endmodule

`default_nettype wire

//--- tb_drr_top.sv
/*
  tb_drr_top: self-checking bench for the request router and channel reset.
  Assumes: drr_top with one wait state per bus access and registered
  request outputs; drr_periph_model drives the request lines.
*/
`timescale 1ns/1ns
`default_nettype none

module tb_drr_top;
  logic                     sys_clk = 1'b0;
  logic                     srst = 1'b1;
  logic [11:0]              addr = 12'h000;
  logic                     rd = 1'b0;
  logic                     wr = 1'b0;
  logic [31:0]              wdata = 32'h0000_0000;
  logic [3:0]               be = 4'hf;
  logic [16:0]              raise = 17'h0_0000;
  logic                     slow = 1'b0;
  logic [4:0]               done_in = 5'h00;
  logic [31:0]              rdata;
  logic                     waitreq;
  logic [4:0]               ch_req;
  logic [4:0]               ch_reset;
  logic [4:0]               done_flag;
  drr_pkg::drr_periph_req_t req;
  logic [31:0]              got;
  logic [31:0]              sel;
  logic [4:0]               rst_or = 5'h00;
  int                       rst_cycles = 0;
  int                       bad_count = 0;
  int                       cmp_count = 0;
  // rows 0..16 route line i; row 17 is the zero code, the rest are reserved codes
  localparam logic [5:0] CODE [25] = '{6'h01, 6'h04, 6'h05, 6'h06, 6'h07,
    6'h0a, 6'h0b, 6'h0c, 6'h0d, 6'h14, 6'h15, 6'h16, 6'h17, 6'h20, 6'h21,
    6'h22, 6'h23, 6'h00, 6'h08, 6'h0e, 6'h13, 6'h18, 6'h1f, 6'h24, 6'h3f};
  // every mapped word; all of them read zero after a reset
  localparam logic [11:0] RST_ADDR [5] = '{12'h424, 12'h460, 12'h480,
    12'h484, 12'h490};

  drr_top drr_top_i (
    .i_sys_clk        (sys_clk),
    .i_srst           (srst),
    .i_clk_en         (1'b1),
    .i_avs_address    (addr),
    .i_avs_read       (rd),
    .i_avs_write      (wr),
    .i_avs_writedata  (wdata),
    .i_avs_byteenable (be),
    .o_avs_readdata   (rdata),
    .o_avs_waitrequest(waitreq),
    .i_periph_req     (req),
    .i_ch_done        (done_in),
    .o_ch_req         (ch_req),
    .o_ch_reset       (ch_reset),
    .o_ch_done_flag   (done_flag)
  );

  drr_periph_model drr_periph_model_i (
    .i_sys_clk(sys_clk),
    .i_raise  (raise),
    .i_slow   (slow),
    .o_req    (req)
  );

  always #20 sys_clk = ~sys_clk;

  // totals only grow, so each pulse is checked by its increment
  always @(posedge sys_clk) begin
    if (ch_reset !== 5'h00) begin
      rst_or <= rst_or | ch_reset;
      rst_cycles <= rst_cycles + 1;
    end
  end

  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(logic [31:0] g, logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic bus(logic w, logic [11:0] a, logic [31:0] d, logic [3:0] b);
    int n;
    @(posedge sys_clk);
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= d;
    be <= b;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (waitreq !== 1'b0 && n < 20);
    got = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    if (waitreq !== 1'b0) begin
      bad_count++;
      tally_and_finish();
    end
  endtask

  task automatic lines(logic [16:0] l, logic s);
    @(posedge sys_clk);
    raise <= l;
    slow <= s;
    repeat (4) @(posedge sys_clk);
  endtask

  task automatic all_zero();
    for (int k = 0; k < 5; k++) begin
      bus(1'b0, RST_ADDR[k], 32'h0, 4'hf);
      check(got, 32'h0);
    end
  endtask

  initial begin
    repeat (20) @(posedge sys_clk);
    srst <= 1'b0;
    // reset values, and nothing routed with every line high
    all_zero();
    lines(17'h1_ffff, 1'b0);
    check(ch_req, 5'h00);
    $display("reset test done");
    // one channel at a time selects a source, so no source is shared
    for (int i = 0; i < 25; i++) begin
      sel = (i % 5 == 4) ? 32'h0 : 32'(CODE[i]) << (8 * (i % 5));
      bus(1'b1, 12'h480, sel, 4'hf);
      bus(1'b1, 12'h484, (i % 5 == 4) ? 32'(CODE[i]) : 32'h0, 4'hf);
      bus(1'b0, 12'h480, 32'h0, 4'hf);
      check(got, sel);
      lines((i < 17) ? 17'h1 << i : 17'h1_ffff, i[0]);
      check(ch_req, (i < 17) ? 5'h1 << (i % 5) : 5'h0);
      lines((i < 17) ? ~(17'h1 << i) : 17'h0, i[0]);
      check(ch_req, 5'h00);
    end
    bus(1'b1, 12'h484, 32'h0, 4'hf);
    $display("routing table done");
    // done flags: set by pulse, cleared by writing one
    @(posedge sys_clk);
    done_in <= 5'h12;
    @(posedge sys_clk);
    done_in <= 5'h00;
    repeat (2) @(posedge sys_clk);
    check(done_flag, 5'h12);
    bus(1'b0, 12'h424, 32'h0, 4'hf);
    check(got, 32'h12);
    bus(1'b1, 12'h424, 32'h02, 4'hf);
    @(posedge sys_clk);
    check(done_flag, 5'h10);
    // a finish in the very cycle that its clear is taken keeps the flag
    fork
      bus(1'b1, 12'h424, 32'h10, 4'hf);
      begin
        @(posedge sys_clk);
        done_in <= 5'h10;
        @(posedge sys_clk);
        done_in <= 5'h00;
      end
    join
    check(done_flag, 5'h10);
    $display("done flag test done");
    // channel reset: ones pulse once, zeros leave channels alone
    bus(1'b1, 12'h460, 32'h15, 4'hf);
    repeat (2) @(posedge sys_clk);
    check(rst_or, 5'h15);
    check(rst_cycles, 1);
    check(done_flag, 5'h00);
    bus(1'b1, 12'h460, 32'h0a, 4'hf);
    repeat (2) @(posedge sys_clk);
    check(rst_or, 5'h1f);
    check(rst_cycles, 2);
    bus(1'b0, 12'h460, 32'h0, 4'hf);
    check(got, 32'h0);
    $display("channel reset test done");
    // memory-to-memory channel ignores its selector
    bus(1'b1, 12'h480, 32'h20, 4'hf);
    lines(17'h0_2000, 1'b0);
    check(ch_req, 5'h01);
    bus(1'b1, 12'h490, 32'h01, 4'hf);
    repeat (3) @(posedge sys_clk);
    check(ch_req, 5'h00);
    bus(1'b1, 12'h490, 32'h00, 4'hf);
    $display("memory to memory test done");
    // a single lane touches one selector; unmapped place reads zero
    bus(1'b1, 12'h480, 32'h3f3f_3f3f, 4'h2);
    bus(1'b0, 12'h480, 32'h0, 4'hf);
    check(got, 32'h0000_3f20);
    bus(1'b1, 12'h4f0, 32'hffff_ffff, 4'hf);
    bus(1'b0, 12'h4f0, 32'h0, 4'hf);
    check(got, 32'h0);
    bus(1'b0, 12'h484, 32'h0, 4'hf);
    check(got, 32'h0);
    $display("lane and unmapped test done");
    // reset in mid-run: selectors set above and the live routed request
    // must all fall back to zero
    @(posedge sys_clk);
    srst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    srst <= 1'b0;
    all_zero();
    check({ch_req, ch_reset, done_flag}, 15'h0);
    $display("mid-run reset test done");
    tally_and_finish();
  end
endmodule

`default_nettype wire
